// >>> bvcr_capture.sv
// embedded-sync video capture: decode, top-field select, half scale, adjust, rgb565
// assumes video_in_clock is slower than clk/2 so its rising edges are seen by sampling
`timescale 1ns/1ns
module bvcr_capture
   import bvcr_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // video link
   input  wire logic        video_in_clock,
   input  wire logic [7:0]  video_in_bus,
   input  wire logic        video_in_vertical_sync,
   input  wire logic        video_in_horizontal_sync,
   // control
   input  wire logic        rec_start,
   input  wire logic        display_active,
   input  wire logic        half_scale,
   input  wire logic [5:0]  field_count,
   input  wire logic [7:0]  contrast,
   input  wire logic [7:0]  brightness,
   input  wire logic        done_enable,
   input  wire logic        done_clear,
   // memory write stream
   output logic             pix_valid,
   output logic [15:0]      pix_data,
   output logic [5:0]       pix_buffer,
   input  wire logic        pix_ready,
   // status
   output logic             recording,
   output logic             field_done,
   output logic             done_event,
   output logic             overflow
);
   logic [1:0] rst_sync;
   logic       rst_n;
   logic [2:0] clk_sync;
   logic [7:0] bus_s1;
   logic [7:0] bus_s2;
   logic       vclk_rise;

   bvcr_sync_t  sync_st,  next_sync_st;
   bvcr_phase_t phase,    next_phase;
   logic        field,    next_field;
   logic        active,   next_active;
   logic        line_odd, next_line_odd;
   logic        rec,      next_rec;
   logic [5:0]  buf_idx,  next_buf_idx;
   logic        flag,     next_flag;
   logic        ovf,      next_ovf;
   logic        seen_top, next_seen_top;
   logic        in_line,  next_in_line;
   logic [10:0] luma_n,   next_luma_n;
   logic [7:0]  cb,       next_cb;
   logic [7:0]  cr,       next_cr;
   logic        wr_v,     next_wr_v;
   logic [15:0] wr_d,     next_wr_d;
   logic        fifo_rdy;
   logic        fifo_ov;
   logic [15:0] fifo_od;
   logic        eof_pulse;

   // unsigned clamp of a signed sum to 0..255
   function automatic logic [7:0] clamp8(input logic signed [19:0] v);
      if (v < 0) return 8'h00;
      if (v > 255) return 8'hFF;
      return v[7:0];
   endfunction

   // contrast is a 1.7 gain around black, brightness signed offset
   function automatic logic [7:0] adjust(input logic [7:0] y, input logic [7:0] c, input logic [7:0] b);
      logic signed [17:0] p;
      p = 18'(($signed({1'b0, y}) - 18'sd16) * $signed({1'b0, c})) >>> 7;
      return clamp8(20'(p + 18'sd16 + 18'($signed(b))));
   endfunction

   // integer bt.601 yuv to rgb565
   function automatic logic [15:0] to565(input logic [7:0] y, input logic [7:0] u, input logic [7:0] v);
      // 20 bits so saturated blue or red cannot wrap to black
      logic signed [19:0] yy;
      logic signed [19:0] du;
      logic signed [19:0] dv;
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
      yy = ($signed({12'h000, y}) - 20'sd16) * 20'sd298;
      du = $signed({12'h000, u}) - 20'sd128;
      dv = $signed({12'h000, v}) - 20'sd128;
      r  = clamp8((yy + dv * 20'sd409 + 20'sd128) >>> 8);
      g  = clamp8((yy - du * 20'sd100 - dv * 20'sd208 + 20'sd128) >>> 8);
      b  = clamp8((yy + du * 20'sd516 + 20'sd128) >>> 8);
      return {r[7:3], g[7:2], b[7:3]};
   endfunction

   // reset release through two flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // link bus through two flops, link clock through three; sync pins are not sampled at all
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_sync <= 3'h0;
         bus_s1   <= 8'h00;
         bus_s2   <= 8'h00;
      end else begin
         clk_sync <= {clk_sync[1:0], video_in_clock};
         bus_s1   <= video_in_bus;
         bus_s2   <= bus_s1;
      end
   end
   // edge from second and third stages only
   assign vclk_rise = clk_sync[1] && !clk_sync[2];

   always_comb begin
      next_sync_st  = sync_st;
      next_phase    = phase;
      next_field    = field;
      next_active   = active;
      next_line_odd = line_odd;
      next_rec      = rec;
      next_buf_idx  = buf_idx;
      next_flag     = flag;
      next_ovf      = ovf;
      next_seen_top = seen_top;
      next_in_line  = in_line;
      next_luma_n   = luma_n;
      next_cb       = cb;
      next_cr       = cr;
      next_wr_v     = wr_v && !fifo_rdy;
      next_wr_d     = wr_d;
      eof_pulse     = 1'b0;
      // start refused while display owns the path
      if (rec_start && !rec && !display_active) begin
         next_rec      = 1'b1;
         next_buf_idx  = 6'h00;
         next_seen_top = 1'b0;
         next_ovf      = 1'b0;
      end
      if (vclk_rise) begin
         case (sync_st)
            bvcr_ff: next_sync_st = (bus_s2 == PRE_ZERO) ? bvcr_z1 : bvcr_idle;
            bvcr_z1: next_sync_st = (bus_s2 == PRE_ZERO) ? bvcr_z2 : bvcr_idle;
            bvcr_z2: begin
               next_sync_st = bvcr_idle;
               // status byte checked by marker and protection bits
               if (bus_s2[BIT_MARK] && bus_s2[3:0] == {bus_s2[5] ^ bus_s2[4], bus_s2[6] ^ bus_s2[4],
                                                        bus_s2[6] ^ bus_s2[5], ^bus_s2[6:4]}) begin
                  if (!bus_s2[BIT_EAV]) begin
                     next_field   = bus_s2[BIT_FIELD];
                     next_active  = !bus_s2[BIT_BLANK];
                     next_in_line = !bus_s2[BIT_BLANK];
                     next_luma_n  = 11'h000;
                     next_phase   = bvcr_cb;
                     if (!bus_s2[BIT_BLANK] && !active) begin
                        next_line_odd = 1'b0;
                     end
                  end else begin
                     next_in_line = 1'b0;
                     if (!bus_s2[BIT_FIELD]) begin
                        next_line_odd = !line_odd;
                     end
                     // top field ends when blanking or bottom field follows active top lines
                     if ((bus_s2[BIT_BLANK] || bus_s2[BIT_FIELD]) && active && !field && seen_top) begin
                        eof_pulse = 1'b1;
                     end
                  end
               end
            end
            default: begin
               if (bus_s2 == PRE_ONES) begin
                  next_sync_st = bvcr_ff;
               end
            end
         endcase
         if (bus_s2 == PRE_ONES) begin
            next_in_line = 1'b0;
         end else if (in_line && sync_st == bvcr_idle) begin
            // samples in Cb Y Cr Y order
            case (phase)
               bvcr_cb: begin
                  next_cb    = bus_s2;
                  next_phase = bvcr_y0;
               end
               bvcr_cr: begin
                  next_cr    = bus_s2;
                  next_phase = bvcr_y1;
               end
               default: begin
                  next_phase  = (phase == bvcr_y0) ? bvcr_cr : bvcr_cb;
                  next_luma_n = luma_n + 11'h001;
                  if (luma_n == LUMA_LAST) begin
                     next_in_line = 1'b0;
                  end
                  // top field only; half scale drops odd lines and odd pixels
                  if (rec && !field && active && (!half_scale || (!line_odd && !luma_n[0]))) begin
                     next_seen_top = 1'b1;
                     next_wr_d     = to565(adjust(bus_s2, contrast, brightness), cb, cr);
                     if (wr_v && !fifo_rdy) begin
                        next_ovf = 1'b1;
                     end
                     next_wr_v = 1'b1;
                  end
               end
            endcase
         end
      end
      if (eof_pulse && rec) begin
         next_seen_top = 1'b0;
         next_buf_idx  = buf_idx + 6'h01;
         if (buf_idx + 6'h01 >= ((field_count == 6'h00) ? FIELDS_DEF : field_count)) begin
            next_rec = 1'b0;
         end
      end
      // set beats clear
      if (eof_pulse && rec) begin
         next_flag = 1'b1;
      end else if (done_clear) begin
         next_flag = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_st  <= bvcr_idle;
         phase    <= bvcr_cb;
         field    <= 1'b0;
         active   <= 1'b0;
         line_odd <= 1'b0;
         rec      <= 1'b0;
         buf_idx  <= 6'h00;
         flag     <= 1'b0;
         ovf      <= 1'b0;
         seen_top <= 1'b0;
         in_line  <= 1'b0;
         luma_n   <= 11'h000;
         cb       <= 8'h80;
         cr       <= 8'h80;
         wr_v     <= 1'b0;
         wr_d     <= 16'h0000;
      end else begin
         sync_st  <= next_sync_st;
         phase    <= next_phase;
         field    <= next_field;
         active   <= next_active;
         line_odd <= next_line_odd;
         rec      <= next_rec;
         buf_idx  <= next_buf_idx;
         flag     <= next_flag;
         ovf      <= next_ovf;
         seen_top <= next_seen_top;
         in_line  <= next_in_line;
         luma_n   <= next_luma_n;
         cb       <= next_cb;
         cr       <= next_cr;
         wr_v     <= next_wr_v;
         wr_d     <= next_wr_d;
      end
   end

   // pixel path buffered so memory stalls are absorbed
   bvcr_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (wr_v),
      .in_data   (wr_d),
      .in_ready  (fifo_rdy),
      .out_valid (fifo_ov),
      .out_data  (fifo_od),
      .out_ready (pix_ready && !pix_valid)
   );

   // registered outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pix_valid  <= 1'b0;
         pix_data   <= 16'h0000;
         pix_buffer <= 6'h00;
         recording  <= 1'b0;
         field_done <= 1'b0;
         done_event <= 1'b0;
         overflow   <= 1'b0;
      end else begin
         pix_valid  <= fifo_ov && pix_ready && !pix_valid;
         pix_data   <= fifo_od;
         pix_buffer <= buf_idx;
         recording  <= rec;
         field_done <= flag;
         done_event <= flag && done_enable;
         overflow   <= ovf;
      end
   end

   busy_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
      display_active && !rec |=> !rec) else $error("record started during display");
   flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      flag && !done_clear |=> flag) else $error("done flag dropped without clear");
   event_out_a: assert property (@(posedge clk) disable iff (!rst_n)
      flag && done_enable |=> done_event) else $error("event not raised");
   stop_count_a: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(rec) |-> buf_idx != 6'h00) else $error("stopped with no field");
   top_only_a: assert property (@(posedge clk) disable iff (!rst_n)
      field && !wr_v |=> !wr_v) else $error("bottom field pixel written");
   blank_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
      !active && !wr_v |=> !wr_v) else $error("blanking line pixel written");
endmodule

// >>> bvcr_pkg.sv
// package for the video capture/record block: constants and state types
// assumes a 100 MHz core clock; the video link clock is sampled, not used as a clock
package bvcr_pkg;
   localparam logic [7:0]  PRE_ONES      = 8'hFF;
   localparam logic [7:0]  PRE_ZERO      = 8'h00;
   localparam int          BIT_MARK      = 7;
   localparam int          BIT_FIELD     = 6;
   localparam int          BIT_BLANK     = 5;
   localparam int          BIT_EAV       = 4;
   localparam int          LINE_SAMPLES  = 1716;
   localparam int          SAV_LAST      = 276;
   localparam int          LUMA_PER_LINE = 720;
   localparam logic [10:0] LUMA_LAST     = 11'h2CF;
   localparam logic [5:0]  FIELDS_DEF    = 6'h1E;
   localparam logic [7:0]  CONTRAST_DEF  = 8'h80;
   localparam logic [7:0]  BRIGHT_DEF    = 8'h00;
   localparam int          FIFO_DEPTH    = 8;
   localparam int          FIFO_WIDTH    = 16;
   typedef enum logic [1:0] {bvcr_ff, bvcr_z1, bvcr_z2, bvcr_idle} bvcr_sync_t;
   typedef enum logic [1:0] {bvcr_cb, bvcr_y0, bvcr_cr, bvcr_y1} bvcr_phase_t;
endpackage

// >>> bvcr_fifo.sv
// parameterised flop FIFO, valid/ready on both sides
// assumes one clock and a synchronous-released active-low reset
`timescale 1ns/1ns
module bvcr_fifo
   import bvcr_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // fill side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // drain side
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];

   always_comb begin
      push        = in_valid && in_ready;
      pop         = out_valid && out_ready;
      next_wr_ptr = push ? AW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
      next_rd_ptr = pop ? AW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
      next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // storage has no reset; out_data shows mem[rd_ptr] even when empty, but only counted words are popped
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule

// >>> bvcr_decoder.sv
// behavioural model of the external video decoder feeding an embedded-sync byte stream
// assumes the bench calls send_line; the link clock stands low between lines
`timescale 1ns/1ns
module bvcr_decoder (
   // video link
   output logic       video_in_clock,
   output logic [7:0] video_in_bus
);
   initial begin
      video_in_clock = 1'b0;
      video_in_bus   = 8'h00;
   end

   // status byte: fixed mark, field, blanking, end flag, then protection
   function automatic logic [7:0] status(input logic f, input logic v, input logic h);
      return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
   endfunction

   // byte changes on the falling edge, held over the rising one
   task automatic put(input logic [7:0] b);
      video_in_bus = b;
      #40 video_in_clock = 1'b1;
      #40 video_in_clock = 1'b0;
   endtask

   task automatic code(input logic [7:0] s);
      put(8'hFF);
      put(8'h00);
      put(8'h00);
      put(s);
   endtask

   // one line; nq quads of samples, bad spoils the start code
   task automatic send_line(input logic f, input logic v, input int nq,
                            input logic [7:0] y, input logic [7:0] c, input logic bad);
      #7;
      code(status(f, v, 1'b1));
      for (int i = 5; i < 273; i++) put(i[0] ? 8'h10 : 8'h80);
      code(status(f, v, 1'b0) ^ {7'h00, bad});
      for (int k = 0; k < 4 * nq; k++) put(k[0] ? y : c);
      video_in_bus = ~video_in_bus;
   endtask
endmodule

// >>> testbench.sv
// self-checking bench for the video capture block, fed by the decoder model
// assumes bvcr_pkg, bvcr_capture and bvcr_decoder are compiled before it
`timescale 1ns/1ns
module testbench
   import bvcr_pkg::*;
;
   // clock and reset
   logic        clk;
   logic        nrst                     = 1'b0;
   // video link
   logic        video_in_clock;
   logic [7:0]  video_in_bus;
   logic        video_in_vertical_sync   = 1'b0;
   logic        video_in_horizontal_sync = 1'b0;
   // control
   logic        rec_start                = 1'b0;
   logic        display_active           = 1'b0;
   logic        half_scale               = 1'b0;
   logic [5:0]  field_count              = 6'h01;
   logic [7:0]  contrast                 = 8'h80;
   logic [7:0]  brightness               = 8'h00;
   logic        done_enable              = 1'b1;
   logic        done_clear               = 1'b0;
   logic        pix_ready                = 1'b1;
   // outputs
   logic        pix_valid;
   logic [15:0] pix_data;
   logic [5:0]  pix_buffer;
   logic        recording;
   logic        field_done;
   logic        done_event;
   logic        overflow;
   // bench state
   int          fail_count               = 0;
   int          checks_done              = 0;
   int          pix_cnt                  = 0;
   logic [15:0] last_pix                 = 16'h0000;
   logic [5:0]  last_buf                 = 6'h00;
   logic [4:0]  red_dark;

   bvcr_capture i_bvcr_capture (
      .clk                      (clk),
      .nrst                     (nrst),
      .video_in_clock           (video_in_clock),
      .video_in_bus             (video_in_bus),
      .video_in_vertical_sync   (video_in_vertical_sync),
      .video_in_horizontal_sync (video_in_horizontal_sync),
      .rec_start                (rec_start),
      .display_active           (display_active),
      .half_scale               (half_scale),
      .field_count              (field_count),
      .contrast                 (contrast),
      .brightness               (brightness),
      .done_enable              (done_enable),
      .done_clear               (done_clear),
      .pix_valid                (pix_valid),
      .pix_data                 (pix_data),
      .pix_buffer               (pix_buffer),
      .pix_ready                (pix_ready),
      .recording                (recording),
      .field_done               (field_done),
      .done_event               (done_event),
      .overflow                 (overflow)
   );

   bvcr_decoder i_bvcr_decoder (
      .video_in_clock (video_in_clock),
      .video_in_bus   (video_in_bus)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // sync pins keep moving so any use of them would disturb capture
   always @(posedge clk) begin
      video_in_horizontal_sync <= ~video_in_horizontal_sync;
      video_in_vertical_sync   <= video_in_horizontal_sync;
   end

   always @(posedge clk) begin
      if (pix_valid === 1'b1) begin
         pix_cnt  <= pix_cnt + 1;
         last_pix <= pix_data;
         last_buf <= pix_buffer;
      end
   end

   task automatic check_bit(input string name, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic do_reset();
      @(posedge clk);
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      cycles(3);
   endtask

   task automatic pulse_start();
      @(posedge clk);
      rec_start <= 1'b1;
      @(posedge clk);
      rec_start <= 1'b0;
      cycles(3);
   endtask

   task automatic t_reset();
      check_bit("recording", 1'b0, recording);
      check_bit("field_done", 1'b0, field_done);
      check_bit("done_event", 1'b0, done_event);
      check_bit("overflow", 1'b0, overflow);
   endtask

   task automatic t_exclusive();
      @(posedge clk);
      display_active <= 1'b1;
      pulse_start();
      check_bit("recording blocked", 1'b0, recording);
      @(posedge clk);
      display_active <= 1'b0;
      pulse_start();
      check_bit("recording", 1'b1, recording);
   endtask

   task automatic t_record();
      pix_cnt = 0;
      i_bvcr_decoder.send_line(1'b1, 1'b0, 360, 8'h60, 8'h80, 1'b0);
      cycles(50);
      check_val("bottom pixels", 16'h0000, 16'(pix_cnt));
      i_bvcr_decoder.send_line(1'b0, 1'b0, 360, 8'h60, 8'h80, 1'b1);
      cycles(50);
      check_val("bad code pixels", 16'h0000, 16'(pix_cnt));
      i_bvcr_decoder.send_line(1'b0, 1'b0, 360, 8'h60, 8'h80, 1'b0);
      cycles(50);
      check_val("top pixels", 16'(LUMA_PER_LINE), 16'(pix_cnt));
      check_bit("grey pixel", 1'b1, last_pix[15:11] === last_pix[4:0]);
      check_val("buffer", 16'h0000, {10'h000, last_buf});
      red_dark = last_pix[15:11];
      i_bvcr_decoder.send_line(1'b0, 1'b1, 0, 8'h60, 8'h80, 1'b0);
      cycles(50);
      check_bit("field_done", 1'b1, field_done);
      check_bit("done_event", 1'b1, done_event);
      check_bit("stopped", 1'b0, recording);
      @(posedge clk);
      done_enable <= 1'b0;
      cycles(3);
      check_bit("event masked", 1'b0, done_event);
      check_bit("flag kept", 1'b1, field_done);
      @(posedge clk);
      done_clear <= 1'b1;
      @(posedge clk);
      done_clear <= 1'b0;
      cycles(3);
      check_bit("flag cleared", 1'b0, field_done);
   endtask

   task automatic t_half();
      @(posedge clk);
      half_scale  <= 1'b1;
      brightness  <= 8'h40;
      field_count <= 6'h02;
      done_enable <= 1'b1;
      pulse_start();
      pix_cnt = 0;
      i_bvcr_decoder.send_line(1'b0, 1'b0, 360, 8'h60, 8'h80, 1'b0);
      i_bvcr_decoder.send_line(1'b0, 1'b0, 360, 8'h60, 8'h80, 1'b0);
      cycles(50);
      check_val("half pixels", 16'(LUMA_PER_LINE / 2), 16'(pix_cnt));
      check_bit("brighter", 1'b1, last_pix[15:11] > red_dark);
      i_bvcr_decoder.send_line(1'b0, 1'b1, 0, 8'h60, 8'h80, 1'b0);
      cycles(50);
      check_bit("field_done", 1'b1, field_done);
      check_bit("still recording", 1'b1, recording);
      check_val("next buffer", 16'h0001, {10'h000, pix_buffer});
   endtask

   // a stalled sink lets the buffer fill, then the rest is lost
   task automatic t_overflow();
      do_reset();
      @(posedge clk);
      half_scale  <= 1'b0;
      field_count <= 6'h01;
      pix_ready   <= 1'b0;
      pulse_start();
      pix_cnt = 0;
      i_bvcr_decoder.send_line(1'b0, 1'b0, 20, 8'h60, 8'h80, 1'b0);
      cycles(10);
      check_bit("overflow", 1'b1, overflow);
      check_val("stalled pixels", 16'h0000, 16'(pix_cnt));
      @(posedge clk);
      pix_ready <= 1'b1;
      cycles(50);
      // the holding stage in front of the buffer keeps one word more
      check_val("drained pixels", 16'(FIFO_DEPTH + 1), 16'(pix_cnt));
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #900000;
      fail_count++;
      $display("mismatch watchdog expected done seen hang");
      finish_test();
   end

   initial begin
      do_reset();
      t_reset();
      t_exclusive();
      t_record();
      t_half();
      t_overflow();
      finish_test();
   end
endmodule
